/* logic/pbs_pkg.sv */
package pbs_pkg;
   // ------------------------------------------------------------------
   // geometry
   // ------------------------------------------------------------------
   localparam int unsigned PBS_LANES  = 4;   // byte lanes per word
   localparam int unsigned PBS_LANE_W = 9;   // eight data bits plus one parity bit
   localparam int unsigned PBS_ADDR_W = 19;  // word address width
   localparam int unsigned PBS_LO_W   = 2;   // burst counter width (wraps at four)

   // ------------------------------------------------------------------
   // reset values and burst step
   // ------------------------------------------------------------------
   localparam logic [PBS_LO_W-1:0] PBS_POS_RST  = 2'h0;  // burst position after reset
   localparam logic [PBS_LO_W-1:0] PBS_POS_STEP = 2'h1;  // one step through the sequence
   localparam logic                PBS_OE_RST   = 1'h1;  // output enable seen as off
   localparam logic                PBS_MODE_RST = 1'h1;  // strap seen as interleaved

   // access state: deselected, first cycle of a processor strobe, burst running
   typedef enum logic [1:0] {
      PBS_DESEL,
      PBS_FIRST,
      PBS_BURST
   } pbs_state_t;

   // synchronous control pins, all sampled on the rising clock edge
   typedef struct packed {
      logic                 proc_addr_strobe_n;   // processor address strobe
      logic                 ctrl_addr_strobe_n;   // controller address strobe
      logic                 burst_step_n;         // advance the burst address
      logic                 global_write_n;       // write all lanes
      logic                 byte_write_enable_n;  // qualifies the lane selects
      logic [PBS_LANES-1:0] byte_lane_select_n;   // per-lane write select
      logic                 chip_select_a_n;      // pipelining select, active low
      logic                 chip_select_b;        // depth select, active high
      logic                 chip_select_c_n;      // depth select, active low
   } pbs_ctl_t;
endpackage : pbs_pkg

/* logic/pbs_sram.sv */
`timescale 1ns/1ps
// Summary of operation
// R1 - write data captured from bus at edge
// R2 - read returns location sampled one edge earlier
// R3 - output enable low drives, high floats bus
// R4 - strap low linear, high interleaved, static
// R5 - inputs sampled at edge, outputs registered
// R6 - two-bit wrap counter loads, steps on advance
// R7 - global write writes every lane
// R8 - byte write updates only selected lanes
// R9 - processor strobe ignored when select A high
// R10 - read starts on strobe, selected, no write
// R11 - start loads address and burst counter
// R12 - read data driven one edge after address
// R13 - first cycle after deselect stays floating
// R14 - deselect with strobe floats bus at once
// R15 - back-to-back single reads accepted
// R16 - processor strobe write loads address first edge
// R17 - first processor cycle ignores write and advance
// R18 - global write low at second edge writes all
// R19 - otherwise byte enables pick written lanes
// R20 - master raises output enable before writing
// R21 - drivers off whenever a write is seen
// R22 - both strobes low: processor strobe wins
// R23 - selects active low/high/low, sampled on load
// R24 - advance low steps burst, reads and writes
// R25 - counter from low address bits, table order
// R26 - lanes carry parity bit, same write control
// R27 - no advance repeats the same location
module pbs_sram #(
   parameter int unsigned LANES  = pbs_pkg::PBS_LANES,
   parameter int unsigned LANE_W = pbs_pkg::PBS_LANE_W,
   parameter int unsigned ADDR_W = pbs_pkg::PBS_ADDR_W
) (
   input  wire logic                    ref_clk,
   input  wire logic                    rst_n,
   input  wire logic                    clk_en,
   input  wire logic [ADDR_W-1:0]       addr,
   input  wire pbs_pkg::pbs_ctl_t       ctl,
   input  wire logic                    out_enable_n,
   input  wire logic                    burst_order,
   input  wire logic [LANES*LANE_W-1:0] bus_data_i,
   output      logic [LANES*LANE_W-1:0] bus_data_o,
   output      logic                    bus_data_oe
);
   localparam int unsigned LO = pbs_pkg::PBS_LO_W;
   localparam int unsigned WORDS = 2 ** ADDR_W;

   // ------------------------------------------------------------------
   // burst address order
   // ------------------------------------------------------------------
   // both tables step a position 0..3; linear adds it, interleaved xors it
   function automatic logic [LO-1:0] burst_lo(input logic [LO-1:0] first,
                                              input logic [LO-1:0] pos,
                                              input logic          ilv);
      burst_lo = ilv ? (first ^ pos) : LO'(first + pos);  // R25
   endfunction : burst_lo

   // ------------------------------------------------------------------
   // storage
   // ------------------------------------------------------------------
   logic [LANES-1:0][LANE_W-1:0] mem [0:WORDS-1];  // array, each lane holds its parity bit

   // ------------------------------------------------------------------
   // asynchronous pin synchronisers
   // ------------------------------------------------------------------
   logic oe_meta_q, oe_meta_d;      // output enable, first stage
   logic oe_s_q, oe_s_d;            // output enable, safe to use
   logic mode_meta_q, mode_meta_d;  // burst order strap, first stage
   logic mode_s_q, mode_s_d;        // burst order strap, safe to use

   // output enable arrives two edges late; a trade for a clean registered drive
   always_comb begin
      oe_meta_d   = out_enable_n;
      oe_s_d      = oe_meta_q;
      mode_meta_d = burst_order;
      mode_s_d    = mode_meta_q;  // R4
   end

   // the strap is static, so re-sampling it forever costs nothing
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         oe_meta_q   <= pbs_pkg::PBS_OE_RST;
         oe_s_q      <= pbs_pkg::PBS_OE_RST;
         mode_meta_q <= pbs_pkg::PBS_MODE_RST;
         mode_s_q    <= pbs_pkg::PBS_MODE_RST;
      end else if (clk_en) begin
         oe_meta_q   <= oe_meta_d;
         oe_s_q      <= oe_s_d;
         mode_meta_q <= mode_meta_d;
         mode_s_q    <= mode_s_d;
      end
   end

   // ------------------------------------------------------------------
   // access decode
   // ------------------------------------------------------------------
   pbs_pkg::pbs_state_t  state_q, state_d;  // access state
   logic [ADDR_W-1:0]    acc_q, acc_d;      // address of the current access
   logic [LO-1:0]        first_q, first_d;  // low bits that opened the burst
   logic [LO-1:0]        pos_q, pos_d;      // position in the burst sequence
   logic                 rd_q, rd_d;        // read taken, data due next edge
   logic                 proc_addr_strobe_n_ok;           // processor strobe recognised
   logic                 strobe;            // either strobe recognised
   logic                 chosen;            // all three selects active
   logic                 start;             // new external address loaded
   logic                 desel;             // deselect cycle
   logic                 cont;              // no strobe while selected
   logic                 is_write;          // write pins ask for a write
   logic [LANES-1:0]     lanes;             // lanes that a write touches
   logic                 wr_go;             // array write this edge
   logic [ADDR_W-1:0]    wr_addr;           // array write address
   logic                 load_out;          // output register loads this edge
   logic [LO-1:0]        pos_nx;            // position after one step

   // the processor strobe needs select A low; it beats the controller strobe
   always_comb begin
      proc_addr_strobe_n_ok  = !ctl.proc_addr_strobe_n && !ctl.chip_select_a_n;  // R9 R22
      strobe   = proc_addr_strobe_n_ok || !ctl.ctrl_addr_strobe_n;
      chosen   = !ctl.chip_select_a_n && ctl.chip_select_b && !ctl.chip_select_c_n;  // R23
      start    = strobe && chosen;
      desel    = strobe && !chosen;
      cont     = !strobe && (state_q != pbs_pkg::PBS_DESEL);
      is_write = !ctl.global_write_n ||
                 (!ctl.byte_write_enable_n && !(&ctl.byte_lane_select_n));
      if (!ctl.global_write_n) begin
         lanes = '1;  // R7 R18 R26
      end else if (!ctl.byte_write_enable_n) begin
         lanes = ~ctl.byte_lane_select_n;  // R8 R19 R26
      end else begin
         lanes = '0;
      end
      pos_nx = LO'(pos_q + pbs_pkg::PBS_POS_STEP);
   end

   // ------------------------------------------------------------------
   // next access state and array write
   // ------------------------------------------------------------------
   // a processor strobe holds its write decision until the second edge
   always_comb begin
      state_d  = state_q;
      acc_d    = acc_q;
      first_d  = first_q;
      pos_d    = pos_q;
      rd_d     = 1'b0;
      wr_go    = 1'b0;
      wr_addr  = acc_q;
      load_out = rd_q;  // R2 R12 R15
      if (start) begin
         // load address and counter; the array sees it at once
         acc_d   = addr;  // R11 R16
         first_d = addr[LO-1:0];  // R6 R25
         pos_d   = pbs_pkg::PBS_POS_RST;
         if (proc_addr_strobe_n_ok) begin
            // write pins and advance not looked at this cycle
            state_d = pbs_pkg::PBS_FIRST;  // R17
         end else begin
            state_d = pbs_pkg::PBS_BURST;
            rd_d    = !is_write;  // R10 R15
            wr_go   = is_write;
            wr_addr = addr;
         end
         // a waiting processor access ends as a read
         if (state_q == pbs_pkg::PBS_FIRST) begin
            load_out = 1'b1;
         end
      end else if (desel) begin
         state_d = pbs_pkg::PBS_DESEL;  // R14
         if (state_q == pbs_pkg::PBS_FIRST) begin
            load_out = 1'b1;
         end
      end else if (cont && state_q == pbs_pkg::PBS_FIRST) begin
         // second edge: write to the loaded address, or read it out
         state_d  = pbs_pkg::PBS_BURST;
         wr_go    = is_write;  // R18 R19
         load_out = !is_write;
      end else if (cont) begin
         if (!ctl.burst_step_n) begin
            pos_d = pos_nx;  // R6 R24
            acc_d = {acc_q[ADDR_W-1:LO], burst_lo(first_q, pos_nx, mode_s_q)};  // R25
         end
         // without advance the same word is used again
         wr_addr = acc_d;  // R27
         wr_go   = is_write;
         rd_d    = !is_write;
      end
   end

   // ------------------------------------------------------------------
   // access registers
   // ------------------------------------------------------------------
   // synchronous reset; the array itself is never cleared
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         state_q <= pbs_pkg::PBS_DESEL;
         acc_q   <= '0;
         first_q <= pbs_pkg::PBS_POS_RST;
         pos_q   <= pbs_pkg::PBS_POS_RST;
         rd_q    <= 1'b0;
      end else if (clk_en) begin
         state_q <= state_d;
         acc_q   <= acc_d;
         first_q <= first_d;
         pos_q   <= pos_d;
         rd_q    <= rd_d;
      end
   end

   // lane-wise write with bus data taken at this very edge
   always_ff @(posedge ref_clk) begin
      if (clk_en && rst_n && wr_go) begin
         for (int i = 0; i < LANES; i++) begin
            if (lanes[i]) begin
               mem[wr_addr][i] <= bus_data_i[i*LANE_W +: LANE_W];  // R1 R8
            end
         end
      end
   end

   // ------------------------------------------------------------------
   // output register and drivers
   // ------------------------------------------------------------------
   logic [LANES*LANE_W-1:0] dout_q, dout_d;  // output register
   logic                    valid_q, valid_d;  // output register holds read data
   logic                    drv_q, drv_d;      // bus drivers on
   logic                    fresh_q, fresh_d;  // access opened out of deselect
   logic [LANES*LANE_W-1:0] mem_rd;            // array word under the access

   // a write or a deselect drops the drivers whatever the enable says
   always_comb begin
      mem_rd = mem[acc_q];
      dout_d = load_out ? mem_rd : dout_q;  // R5 R12
      fresh_d = start && (state_q == pbs_pkg::PBS_DESEL);  // R13
      // a deselect wins over a pending read so the bus stays quiet after it
      if (load_out && !desel) begin
         valid_d = 1'b1;
      end else if (desel || wr_go) begin
         valid_d = 1'b0;  // R14
      end else begin
         valid_d = valid_q;
      end
      drv_d = valid_d && !oe_s_q;  // R3
      if (wr_go || desel) begin
         drv_d = 1'b0;  // R14 R21
      end else if (start && state_q == pbs_pkg::PBS_DESEL) begin
         drv_d = 1'b0;  // R13
      end else if (fresh_q) begin
         // the first data out of a deselect is held off one more edge
         drv_d = 1'b0;  // R13
      end
   end

   // relies on the master raising the enable before it drives the bus
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         dout_q  <= '0;
         valid_q <= 1'b0;
         drv_q   <= 1'b0;
         fresh_q <= 1'b0;
      end else if (clk_en) begin
         dout_q  <= dout_d;
         valid_q <= valid_d;
         drv_q   <= drv_d;  // R20
         fresh_q <= fresh_d;
      end
   end

   assign bus_data_o  = dout_q;
   assign bus_data_oe = drv_q;

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n || !clk_en);

   chk_read_data: assert property (rd_q |=> dout_q == $past(mem_rd))  // R2
      else $error("read data not from sampled address");
   chk_write_off: assert property (wr_go |=> !bus_data_oe)  // R21
      else $error("drivers on after a write");
   chk_desel_off: assert property (desel |=> !bus_data_oe)  // R14
      else $error("drivers on after deselect");
   chk_oe_float: assert property (oe_s_q |=> !bus_data_oe)  // R3
      else $error("drivers on while enable high");
   chk_first_mask: assert property (start && state_q == pbs_pkg::PBS_DESEL  // R13
      |=> !bus_data_oe ##1 !bus_data_oe)
      else $error("drivers on in first cycle after deselect");
   chk_desel_stay: assert property (desel ##1 !strobe |=> !bus_data_oe)  // R14
      else $error("drivers on while deselected");
   chk_addr_load: assert property (start |=> acc_q == $past(addr) && pos_q == '0)  // R11
      else $error("address not loaded on start");
   chk_proc_addr_strobe_n_ignored: assert property (!ctl.proc_addr_strobe_n && ctl.chip_select_a_n &&
      ctl.ctrl_addr_strobe_n && ctl.burst_step_n && state_q == pbs_pkg::PBS_BURST
      |=> $stable(acc_q))  // R9
      else $error("processor strobe taken with select A high");
   chk_step_hold: assert property (cont && state_q == pbs_pkg::PBS_BURST && ctl.burst_step_n
      |=> $stable(acc_q) && $stable(pos_q))  // R27
      else $error("burst address moved without advance");
   chk_step_next: assert property (cont && state_q == pbs_pkg::PBS_BURST && !ctl.burst_step_n
      |=> pos_q == LO'($past(pos_q) + 1'b1))  // R24
      else $error("burst address did not step");
   chk_first_wait: assert property (start && proc_addr_strobe_n_ok |-> !wr_go ##1 state_q == pbs_pkg::PBS_FIRST)  // R17
      else $error("processor strobe first cycle not ignored");
endmodule : pbs_sram

/* verification/pbs_host.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------------
// bus master model: strobes, selects, enable and write data
// ------------------------------------------------------------------
module pbs_host (
   input  wire logic              ref_clk,
   input  wire logic              en_off,       // keep output enable off
   input  wire logic [35:0]       bus_data_o,
   input  wire logic              bus_data_oe,
   output      logic [5:0]        addr,
   output      pbs_pkg::pbs_ctl_t ctl,
   output      logic              out_enable_n,
   output      logic [35:0]       bus_data_i
);
   logic [35:0] wr_d_q;  // data the master puts on the bus
   logic        drv_q;   // master drives the bus
   logic [35:0] last_q;  // bus level at the last edge

   initial begin
      addr   = 6'h00;
      ctl    = '1;       // strobes idle, not selected
      wr_d_q = 36'h0;
      drv_q  = 1'b0;
   end

   // enable is raised whenever the master drives; the block sees it two edges late, so without park() a clash can still show
   assign out_enable_n = en_off | drv_q;

   // a clash shows as unknown; a released bus toggles so no stale value lingers
   assign bus_data_i = bus_data_oe ? (drv_q ? 'x : bus_data_o)
                                   : (drv_q ? wr_d_q : ~last_q);

   // remember the bus for the floating pattern
   always_ff @(posedge ref_clk) begin
      last_q <= bus_data_i;
   end

   // one bus cycle, changed at the falling edge
   task automatic put(input logic [5:0] a, input pbs_pkg::pbs_ctl_t c,
                      input logic [35:0] d, input logic w);
      @(negedge ref_clk);
      addr   = a;
      ctl    = c;
      wr_d_q = d;
      drv_q  = w;
   endtask : put
endmodule : pbs_host

/* verification/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
   // ------------------------------------------------------------------
   // signals
   // ------------------------------------------------------------------
   localparam int unsigned AW  = 6;     // short address for simulation
   localparam logic [2:0]  SEL = 3'h2;  // all three selects active
   localparam logic [35:0] M2  = {9'h1ff, 9'h0, 9'h1ff, 9'h0};  // lanes kept
   localparam logic [35:0] M0  = {27'h7ffffff, 9'h0};           // lane 0 open
   logic              ref_clk;
   logic              rst_n;
   logic              burst_order;
   logic              en_off;
   logic [AW-1:0]     addr;
   pbs_pkg::pbs_ctl_t ctl;
   logic              out_enable_n;
   logic [35:0]       bus_i;
   logic [35:0]       bus_o;
   logic              bus_oe;
   int                err_total;
   int                n_tests;

   pbs_sram #(.ADDR_W(AW)) dut_u (
      .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(1'b1), .addr(addr), .ctl(ctl),
      .out_enable_n(out_enable_n), .burst_order(burst_order),
      .bus_data_i(bus_i), .bus_data_o(bus_o), .bus_data_oe(bus_oe));

   pbs_host host_u (
      .ref_clk(ref_clk), .en_off(en_off), .bus_data_o(bus_o),
      .bus_data_oe(bus_oe), .addr(addr), .ctl(ctl),
      .out_enable_n(out_enable_n), .bus_data_i(bus_i));

   // ------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------
   // k packs strobes, step, global write, byte enable in struct order
   function automatic pbs_pkg::pbs_ctl_t ct(input logic [4:0] k,
                                            input logic [3:0] l,
                                            input logic [2:0] s);
      return pbs_pkg::pbs_ctl_t'({k, l, s});
   endfunction : ct

   // every lane differs so a lane mix-up shows
   function automatic logic [35:0] pat(input logic [5:0] i);
      return {i, 3'h4, i, 3'h3, i, 3'h2, i, 3'h1};
   endfunction : pat

   task automatic idle(input int n);
      repeat (n) host_u.put(6'h00, ct(5'h1f, 4'hf, SEL), 36'h0, 1'b0);
   endtask : idle

   // global write with byte enables set, which must not matter
   task automatic wr(input logic [5:0] a, input logic [35:0] d);
      host_u.put(a, ct(5'h14, 4'h6, SEL), d, 1'b1);
   endtask : wr

   task automatic rd(input logic [5:0] a);
      host_u.put(a, ct(5'h17, 4'hf, SEL), 36'h0, 1'b0);
   endtask : rd

   task automatic chk_d(input logic [35:0] e);
      n_tests++;
      if (bus_o !== e) begin
         err_total++;
         $display("wrong value at %0t: expected %h, got %h", $time, e, bus_o);
      end
   endtask : chk_d

   task automatic chk_b(input logic e);
      n_tests++;
      if (bus_oe !== e) begin
         err_total++;
         $display("wrong value at %0t: expected %h, got %h", $time, e, bus_oe);
      end
   endtask : chk_b

   // data of a read lands after the second edge
   task automatic rdchk(input logic [5:0] a, input logic [35:0] e);
      rd(a);
      idle(2);
      chk_d(e);
   endtask : rdchk

   // strap changes only while reset is held
   task automatic do_rst(input logic m);
      @(negedge ref_clk);
      rst_n       = 1'b0;
      burst_order = m;
      idle(5);
      rst_n = 1'b1;
   endtask : do_rst

   // enable goes up three edges ahead, so the block has let go before data is driven
   task automatic park();
      en_off = 1'b1;
      idle(3);
   endtask : park

   // ------------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------------
   task automatic t_rw();
      for (int i = 0; i < 8; i++) wr(6'(i), pat(6'(i)));
      for (int i = 0; i < 10; i++) begin
         if (i < 8) rd(6'(i));
         else idle(1);
         if (i >= 2) chk_d(pat(6'(i - 2)));
      end
      chk_b(1'b1);
   endtask : t_rw

   task automatic t_byte();
      park();
      wr(6'h08, pat(6'h08));
      host_u.put(6'h08, ct(5'h16, 4'ha, SEL), pat(6'h09), 1'b1);
      rdchk(6'h08, (pat(6'h08) & M2) | (pat(6'h09) & ~M2));
   endtask : t_byte

   // both strobes with write pins low: first cycle must not write
   task automatic t_proc();
      wr(6'h0a, pat(6'h0a));
      host_u.put(6'h0a, ct(5'h04, 4'h0, SEL), pat(6'h0b), 1'b1);
      idle(1);
      rdchk(6'h0a, pat(6'h0a));
      host_u.put(6'h0b, ct(5'h0f, 4'hf, SEL), 36'h0, 1'b0);
      host_u.put(6'h3f, ct(5'h1d, 4'hf, SEL), pat(6'h0d), 1'b1);
      rdchk(6'h0b, pat(6'h0d));
      wr(6'h0c, pat(6'h0c));
      host_u.put(6'h0c, ct(5'h0f, 4'hf, SEL), 36'h0, 1'b0);
      host_u.put(6'h0c, ct(5'h1e, 4'he, SEL), pat(6'h0e), 1'b1);
      rdchk(6'h0c, (pat(6'h0c) & M0) | (pat(6'h0e) & ~M0));
   endtask : t_proc

   task automatic t_desel();
      en_off = 1'b0;
      rd(6'h00);
      idle(4);
      chk_b(1'b1);
      host_u.put(6'h00, ct(5'h0f, 4'hf, 3'h6), 36'h0, 1'b0);
      idle(1);
      chk_b(1'b1);
      host_u.put(6'h00, ct(5'h17, 4'hf, 3'h0), 36'h0, 1'b0);
      idle(1);
      chk_b(1'b0);
      rd(6'h01);
      idle(2);
      chk_b(1'b0);
      chk_d(pat(6'h01));
      idle(1);
      chk_b(1'b1);
      en_off = 1'b1;
      idle(4);
      chk_b(1'b0);
      en_off = 1'b0;
      idle(4);
      chk_b(1'b1);
      wr(6'h02, pat(6'h02));
      idle(1);
      chk_b(1'b0);
   endtask : t_desel

   // start at low bits 01, step three times, hold once, step again
   task automatic t_burst(input logic m);
      logic [1:0] p [8];
      logic [1:0] lo;
      do_rst(m);
      for (int i = 0; i < 4; i++) wr(6'(16 + i), pat(6'(16 + i)));
      p[0] = 2'h0;
      for (int j = 0; j < 10; j++) begin
         if (j == 0) rd(6'h11);
         else host_u.put(6'h00, ct((j < 8 && j != 4) ? 5'h1b : 5'h1f, 4'hf, SEL),
                         36'h0, 1'b0);
         if (j > 0 && j < 8) p[j] = p[j - 1] + ((j != 4) ? 2'h1 : 2'h0);
         if (j >= 2) begin
            lo = m ? (2'h1 ^ p[j - 2]) : (2'h1 + p[j - 2]);
            chk_d(pat({4'h4, lo}));
         end
      end
   endtask : t_burst

   // ------------------------------------------------------------------
   // run control
   // ------------------------------------------------------------------
   task automatic stop_test();
      $display("checks %0d, errors %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : stop_test

   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   // whole run is about a hundred and ten cycles; this bound only catches a hang
   initial begin
      repeat (4000) @(posedge ref_clk);
      err_total++;
      stop_test();
   end

   initial begin
      rst_n       = 1'b0;
      burst_order = 1'b1;
      en_off      = 1'b0;
      err_total   = 0;
      n_tests     = 0;
      do_rst(1'b1);
      t_rw();
      t_byte();
      t_proc();
      t_desel();
      t_burst(1'b0);
      t_burst(1'b1);
      stop_test();
   end
endmodule : tb_top
